// *** dds_host.sv ***
// Memory controller end and its read-data FIFO
// Assumes device on the same sys_clk; user side is valid/ready
//
`timescale 1ns/10ps
`include "dds_defines.svh"
module dds_fifo
#(
   parameter int WIDTH = `DDS_DATA_W,
   parameter int DEPTH = `DDS_FIFO_DEPTH
)
(
   input  wire logic             sys_clk,
   input  wire logic             rstn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic [$clog2(DEPTH):0] level
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] buf_mem [0:DEPTH-1];
   logic [PW-1:0]    wr_ptr_reg;
   logic [PW-1:0]    rd_ptr_reg;
   logic [PW:0]      cnt_reg;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_reg != DEPTH[PW:0]);
   assign out_valid = (cnt_reg != '0);
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = buf_mem[rd_ptr_reg];
   assign level     = cnt_reg;

   always_ff @(posedge sys_clk)
   begin
      if (push)
      begin
         buf_mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         cnt_reg    <= '0;
      end
      else
      begin
         wr_ptr_reg <= push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
         rd_ptr_reg <= pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
         cnt_reg    <= cnt_reg + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
      end
   end
endmodule : dds_fifo

////////////////////////////////////////////////////////////////////////////
module dds_host
(
   input  wire logic                          sys_clk,
   input  wire logic                          rstn,
   input  wire logic                          cmd_valid,
   output logic                               cmd_ready,
   input  wire logic                          cmd_write,
   input  wire logic [`DDS_ADDR_W-1:0]        cmd_addr,
   input  wire logic [4*`DDS_DATA_W-1:0]      cmd_wdata,
   input  wire logic [4*`DDS_SEL_W-1:0]       cmd_sel_n,
   output logic                               rd_valid,
   input  wire logic                          rd_ready,
   output logic [`DDS_DATA_W-1:0]             rd_data,
   dds_link_if.host                           link
);
   import dds_pkg::*;

   localparam int DW = `DDS_DATA_W;
   localparam int SW = `DDS_SEL_W;

   dds_host_e                 st_reg;
   logic                      k_phase_reg;
   logic [`DDS_HOST_SKEW-1:0] c_dly_reg;
   logic [1:0]                beat_reg;
   logic [4*DW-1:0]           wbuf_reg;
   logic [4*SW-1:0]           sbuf_reg;
   logic                      wps_n_reg;
   logic                      rps_n_reg;
   logic [`DDS_ADDR_W-1:0]    addr_reg;
   logic                      fifo_in_ready;
   logic [$clog2(`DDS_FIFO_DEPTH):0] fifo_level;
   logic                      cap;

   // Room for a whole burst before a read is issued
   assign cmd_ready = (st_reg == H_IDLE) & k_phase_reg &
                      (cmd_write | (fifo_level <= (`DDS_FIFO_DEPTH - `DDS_BURST)));
   assign cap = link.q_oe & fifo_in_ready;

   // Input clock pair as slot phase; output clock a skewed copy
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         k_phase_reg <= 1'b1;
         c_dly_reg   <= '1;
      end
      else
      begin
         k_phase_reg <= ~k_phase_reg;
         c_dly_reg   <= k_phase_reg;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         st_reg    <= H_IDLE;
         beat_reg  <= 2'h0;
         wbuf_reg  <= '0;
         sbuf_reg  <= '1;
         wps_n_reg <= 1'b1;
         rps_n_reg <= 1'b1;
         addr_reg  <= '0;
      end
      else
      begin
         wps_n_reg <= 1'b1;
         rps_n_reg <= 1'b1;
         case (st_reg)
            H_IDLE:
            begin
               if (cmd_valid & cmd_ready)
               begin
                  addr_reg <= cmd_addr;
                  beat_reg <= 2'h0;
                  if (cmd_write)
                  begin
                     wps_n_reg <= 1'b0;
                     wbuf_reg  <= cmd_wdata;
                     sbuf_reg  <= cmd_sel_n;
                     st_reg    <= H_WR;
                  end
                  else
                  begin
                     rps_n_reg <= 1'b0;
                     st_reg    <= H_RD;
                  end
               end
            end
            H_WR:
            begin
               wbuf_reg <= {{DW{1'b0}}, wbuf_reg[4*DW-1:DW]};
               sbuf_reg <= {{SW{1'b1}}, sbuf_reg[4*SW-1:SW]};
               beat_reg <= beat_reg + 2'h1;
               if (beat_reg == 2'h3)
               begin
                  st_reg <= H_IDLE;
               end
            end
            H_RD:
            begin
               if (cap)
               begin
                  beat_reg <= beat_reg + 2'h1;
                  if (beat_reg == 2'h3)
                  begin
                     st_reg <= H_IDLE;
                  end
               end
            end
            default:
            begin
               st_reg <= H_IDLE;
            end
         endcase
      end
   end

   assign link.k_phase             = k_phase_reg;
   assign link.c_phase             = c_dly_reg[`DDS_HOST_SKEW-1];
   assign link.write_port_select_n = wps_n_reg;
   assign link.read_port_select_n  = rps_n_reg;
   // one address bus for both ports
   assign link.addr                = addr_reg;
   assign link.d                   = wbuf_reg[DW-1:0];
   assign link.byte_write_select_n = sbuf_reg[SW-1:0];

   dds_fifo #(.WIDTH(DW), .DEPTH(`DDS_FIFO_DEPTH)) u_rd_fifo
   (
      .sys_clk   (sys_clk),
      .rstn      (rstn),
      .in_valid  (link.q_oe),
      .in_ready  (fifo_in_ready),
      .in_data   (link.q),
      .out_valid (rd_valid),
      .out_ready (rd_ready),
      .out_data  (rd_data),
      .level     (fifo_level)
   );
endmodule : dds_host

// *** dds_defines.svh ***
// Constants for the burst SRAM pin interface: widths, burst, timing
// Assumes inclusion by bare name from the files that use its macros
`ifndef DDS_DEFINES_SVH
`define DDS_DEFINES_SVH
`define DDS_DATA_W   36
`define DDS_SEL_W    4
`define DDS_ADDR_W   21
`define DDS_LANE_W   9
`define DDS_NIB_W    4
`define DDS_BURST    4
`define DDS_AW_X8    21
`define DDS_AW_X18   20
`define DDS_AW_X36   19
`define DDS_W_X8     8
`define DDS_W_X9     9
`define DDS_W_X18    18
`define DDS_MEM_LOC_W 10
`define DDS_FIFO_DEPTH 8
`define DDS_HOST_SKEW 1
`endif

// *** dds_pkg.sv ***
// Types shared by both ends of the burst SRAM link
// Assumes dds_defines.svh is on the include path
package dds_pkg;
   typedef enum logic [1:0]
   {
      DDS_X8  = 2'h0,
      DDS_X9  = 2'h1,
      DDS_X18 = 2'h2,
      DDS_X36 = 2'h3
   } dds_cfg_e;
   typedef enum logic [2:0]
   {
      RD_IDLE = 3'h1,
      RD_WAIT = 3'h2,
      RD_OUT  = 3'h4
   } dds_rd_e;
   typedef enum logic [2:0]
   {
      H_IDLE = 3'h1,
      H_WR   = 3'h2,
      H_RD   = 3'h4
   } dds_host_e;
endpackage : dds_pkg

// *** dds_link_if.sv ***
// Pin-level link between memory controller and burst SRAM
// Assumes one clock; each cycle is one input-clock edge slot
`timescale 1ns/10ps
`include "dds_defines.svh"
interface dds_link_if;
   logic                    k_phase;
   logic                    c_phase;
   logic                    write_port_select_n;
   logic                    read_port_select_n;
   logic [`DDS_ADDR_W-1:0]  addr;
   logic [`DDS_DATA_W-1:0]  d;
   logic [`DDS_SEL_W-1:0]   byte_write_select_n;
   logic [`DDS_DATA_W-1:0]  q;
   logic                    q_oe;

   modport dev
   (
      input  k_phase, c_phase, write_port_select_n, read_port_select_n,
      input  addr, d, byte_write_select_n,
      output q, q_oe
   );
   modport host
   (
      output k_phase, c_phase, write_port_select_n, read_port_select_n,
      output addr, d, byte_write_select_n,
      input  q, q_oe
   );
endinterface : dds_link_if

// *** dds_device.sv ***
// Burst SRAM device end: write capture, masked array, read burst out
// Assumes host drives link on sys_clk; k_phase 0 marks a K rising slot
// Behaviour
// - Write data captured on K and K# slots
// - Low write select on K starts write
// - Deselected write port ignores data inputs
// - Nibble selects 0,1 govern bits 3:0,7:4
// - High nibble select leaves stored nibble
// - Byte selects per beat choose written bytes
// - Deselected byte keeps previous contents
// - Shared address captured on K rising slot
// - Address width 21, 20 or 19 bits
// - Address ignored when port deselected
// - Read beats on C, or K in single mode
// - Deselected read port tri-states data outputs
// - Read select starts four-beat burst, completes
// - Accesses start only on K rising slot
`timescale 1ns/10ps
`include "dds_defines.svh"
module dds_device
(
   input  wire logic             sys_clk,
   input  wire logic             rstn,
   input  wire dds_pkg::dds_cfg_e cfg,
   input  wire logic             single_clock_mode,
   dds_link_if.dev               link
);
   import dds_pkg::*;

   localparam int LOC_W = `DDS_MEM_LOC_W;
   localparam int IDX_W = LOC_W + 2;

   ////////////////////////////////////////////////////////////////////////
   // Per-bit write enables and active data width
   logic [`DDS_DATA_W-1:0] bit_en;
   logic [`DDS_DATA_W-1:0] act_mask;
   logic [`DDS_SEL_W-1:0]  sel_n;

   assign sel_n = link.byte_write_select_n;

   genvar i;
   generate
      for (i = 0; i < `DDS_DATA_W; i++)
      begin : g_bit
         localparam int NIB  = (i < `DDS_W_X8) ? (i / `DDS_NIB_W) : 0;
         localparam int LANE = i / `DDS_LANE_W;
         always_comb
         begin
            case (cfg)
               DDS_X8:  act_mask[i] = (i < `DDS_W_X8);
               DDS_X9:  act_mask[i] = (i < `DDS_W_X9);
               DDS_X18: act_mask[i] = (i < `DDS_W_X18);
               default: act_mask[i] = 1'b1;
            endcase
         end
         assign bit_en[i] = act_mask[i] &
                            ((cfg == DDS_X8) ? ~sel_n[NIB] : ~sel_n[LANE]);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Address width per configuration
   logic [`DDS_ADDR_W-1:0] addr_eff;

   always_comb
   begin
      case (cfg)
         DDS_X18: addr_eff = link.addr & {1'b0, {`DDS_AW_X18{1'b1}}};
         DDS_X36: addr_eff = link.addr & {2'b00, {`DDS_AW_X36{1'b1}}};
         default: addr_eff = link.addr;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Port selects; read owns the shared address on a tie
   logic k_slot;
   logic rd_start;
   logic wr_start;
   logic wr_busy_reg;
   logic [1:0] wr_beat_reg;
   logic [LOC_W-1:0] wr_loc_reg;
   dds_rd_e rd_state_reg;

   assign k_slot = ~link.k_phase;
   assign rd_start = k_slot & ~link.read_port_select_n & (rd_state_reg == RD_IDLE);
   assign wr_start = k_slot & ~link.write_port_select_n & ~wr_busy_reg &
                     link.read_port_select_n;

   ////////////////////////////////////////////////////////////////////////
   // Write burst tracking
   // four beats over two K cycles
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         wr_busy_reg <= 1'b0;
         wr_beat_reg <= 2'h0;
         wr_loc_reg  <= '0;
      end
      else if (wr_start)
      begin
         wr_busy_reg <= 1'b1;
         wr_beat_reg <= 2'h1;
         wr_loc_reg  <= addr_eff[LOC_W-1:0];
      end
      else if (wr_busy_reg)
      begin
         wr_beat_reg <= wr_beat_reg + 2'h1;
         if (wr_beat_reg == 2'h3)
         begin
            wr_busy_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Storage: locations times four burst words
   logic [`DDS_DATA_W-1:0] mem [0:(1 << IDX_W)-1];
   logic [IDX_W-1:0]       wr_idx;
   logic                   wr_now;

   // data taken only inside a write burst
   assign wr_now = wr_start | wr_busy_reg;
   assign wr_idx = wr_start ? {addr_eff[LOC_W-1:0], 2'h0} : {wr_loc_reg, wr_beat_reg};

   // one beat per K or K# slot
   always_ff @(posedge sys_clk)
   begin
      if (wr_now)
      begin
         mem[wr_idx] <= (mem[wr_idx] & ~bit_en) | (link.d & bit_en);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read burst
   logic [LOC_W-1:0]       rd_loc_reg;
   logic [1:0]             rd_beat_reg;
   logic [`DDS_DATA_W-1:0] q_reg;
   logic                   q_oe_reg;
   logic                   launch;

   // output slot from C, or K in single mode
   assign launch = single_clock_mode ? k_slot : ~link.c_phase;

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         rd_state_reg <= RD_IDLE;
         rd_loc_reg   <= '0;
         rd_beat_reg  <= 2'h0;
         q_reg        <= '0;
         q_oe_reg     <= 1'b0;
      end
      else
      begin
         case (rd_state_reg)
            RD_IDLE:
            begin
               if (rd_start)
               begin
                  rd_loc_reg   <= addr_eff[LOC_W-1:0];
                  rd_state_reg <= RD_WAIT;
               end
            end
            RD_WAIT:
            begin
               if (launch)
               begin
                  q_reg        <= mem[{rd_loc_reg, 2'h0}] & act_mask;
                  q_oe_reg     <= 1'b1;
                  rd_beat_reg  <= 2'h1;
                  rd_state_reg <= RD_OUT;
               end
            end
            RD_OUT:
            begin
               if (rd_beat_reg == 2'h0)
               begin
                  q_oe_reg     <= 1'b0;
                  rd_state_reg <= RD_IDLE;
               end
               else
               begin
                  q_reg       <= mem[{rd_loc_reg, rd_beat_reg}] & act_mask;
                  rd_beat_reg <= rd_beat_reg + 2'h1;
               end
            end
            default:
            begin
               q_oe_reg     <= 1'b0;
               rd_state_reg <= RD_IDLE;
            end
         endcase
      end
   end

   assign link.q    = q_reg;
   assign link.q_oe = q_oe_reg;
endmodule : dds_device

// *** dds_link_chk.sv ***
// Concurrent checks on the controller-to-SRAM pin link
// Assumes one instance beside dds_link_if, all in the sys_clk domain
`timescale 1ns/10ps
module dds_link_chk
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic k_phase,
   input wire logic c_phase,
   input wire logic write_port_select_n,
   input wire logic read_port_select_n,
   input wire logic q_oe
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);

   ////////////////////////////////////////////////////////////
   property p_sel_on_k;
      (!write_port_select_n || !read_port_select_n) |-> !k_phase;
   endproperty
   a_sel_on_k: assert property (p_sel_on_k)
      else $error("select outside K slot");
   property p_k_toggle;
      $past(rstn) |-> k_phase != $past(k_phase);
   endproperty
   a_k_toggle: assert property (p_k_toggle)
      else $error("K slot did not alternate");
   property p_c_skew;
      $past(rstn) |-> c_phase == $past(k_phase);
   endproperty
   a_c_skew: assert property (p_c_skew)
      else $error("output clock slot skew wrong");
   property p_wr_gap;
      !write_port_select_n |=> write_port_select_n [*3];
   endproperty
   a_wr_gap: assert property (p_wr_gap)
      else $error("write reissued inside burst");
   property p_rd_start;
      !read_port_select_n && !q_oe |-> ##[2:4] q_oe;
   endproperty
   a_rd_start: assert property (p_rd_start)
      else $error("read burst did not start");
   property p_oe_len;
      $rose(q_oe) |-> q_oe [*4] ##1 !q_oe;
   endproperty
   a_oe_len: assert property (p_oe_len)
      else $error("read drive not four beats");
   // Drive only follows a read select
   property p_oe_src;
      $rose(q_oe) |-> !$past(read_port_select_n, 2) || !$past(read_port_select_n, 3)
         || !$past(read_port_select_n, 4);
   endproperty
   a_oe_src: assert property (p_oe_src)
      else $error("outputs driven without read");
   property p_oe_no_rd;
      q_oe |-> read_port_select_n;
   endproperty
   a_oe_no_rd: assert property (p_oe_no_rd)
      else $error("read select during burst");
endmodule : dds_link_chk

// *** testbench.sv ***
// Self-checking bench: host and device joined over the pin link
// Assumes the design files and dds_link_chk.sv are compiled first
`timescale 1ns/10ps
`include "dds_defines.svh"
`define CHK(got, exp) \
   begin \
      check_count++; \
      if ((got) !== (exp)) \
      begin \
         n_fail++; \
         $display("Error at %0t: got %h expected %h", $time, got, exp); \
      end \
   end
module testbench;
   import dds_pkg::*;
   typedef struct packed
   {
      dds_cfg_e               cfg;
      logic [`DDS_ADDR_W-1:0] addr;
      logic [`DDS_DATA_W-1:0] pat;
      logic [15:0]            sel;
   } dds_row_s;
   logic                     sys_clk           = 1'b0;
   logic                     rstn              = 1'b0;
   logic                     cmd_valid         = 1'b0;
   logic                     cmd_write         = 1'b0;
   logic [`DDS_ADDR_W-1:0]   cmd_addr          = '0;
   logic [4*`DDS_DATA_W-1:0] cmd_wdata         = '0;
   logic [4*`DDS_SEL_W-1:0]  cmd_sel_n         = '1;
   logic                     rd_ready          = 1'b0;
   logic                     single_clock_mode = 1'b0;
   dds_cfg_e                 cfg               = DDS_X36;
   logic                     cmd_ready;
   logic                     rd_valid;
   logic [`DDS_DATA_W-1:0]   rd_data;
   wire  [`DDS_DATA_W-1:0]   q_wire;
   int                       n_fail            = 0;
   int                       check_count       = 0;
   int                       cyc               = 0;
   logic [`DDS_DATA_W-1:0]   exp4 [4];
   // Boundary locations; top row aliases onto the last stored location
   dds_row_s                 rows [5]          = '{
      '{DDS_X8,  21'h000000, 36'h9A5C31E7B, 16'h1212},
      '{DDS_X9,  21'h0003FF, 36'h3C96A5F01, 16'hE1E0},
      '{DDS_X18, 21'h000155, 36'hF0E1D2C3B, 16'h3C96},
      '{DDS_X36, 21'h0002AA, 36'h123456789, 16'hFFFF},
      '{DDS_X36, 21'h1FFFFF, 36'hFEDCBA987, 16'h5A3C}
   };

   always #25 sys_clk = ~sys_clk;

   dds_link_if u_dds_link_if ();
   // Read data pins as seen on the board
   assign q_wire = u_dds_link_if.q_oe ? u_dds_link_if.q : {`DDS_DATA_W{1'bz}};
   dds_host u_dds_host
   (
      .sys_clk(sys_clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .cmd_sel_n(cmd_sel_n), .rd_valid(rd_valid), .rd_ready(rd_ready),
      .rd_data(rd_data), .link(u_dds_link_if)
   );
   dds_device u_dds_device
   (
      .sys_clk(sys_clk), .rstn(rstn), .cfg(cfg),
      .single_clock_mode(single_clock_mode), .link(u_dds_link_if)
   );
   dds_link_chk u_dds_link_chk
   (
      .sys_clk(sys_clk), .rstn(rstn), .k_phase(u_dds_link_if.k_phase),
      .c_phase(u_dds_link_if.c_phase), .q_oe(u_dds_link_if.q_oe),
      .write_port_select_n(u_dds_link_if.write_port_select_n),
      .read_port_select_n(u_dds_link_if.read_port_select_n)
   );

   ////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up

   // Ceiling about sixteen times the expected run
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_fail++;
         wrap_up();
      end
   end

   function automatic logic [`DDS_DATA_W-1:0] exp_word(input dds_cfg_e c,
      input logic [`DDS_DATA_W-1:0] a, input logic [`DDS_DATA_W-1:0] b, input logic [3:0] s);
      logic [`DDS_DATA_W-1:0] r;
      r = '0;
      for (int i = 0; i < 36; i++)
      begin
         if (c == DDS_X8 && i < 8)
            r[i] = s[i / 4] ? a[i] : b[i];
         else if (c == DDS_X36 || (c == DDS_X18 && i < 18) || (c == DDS_X9 && i < 9))
            r[i] = s[i / 9] ? a[i] : b[i];
      end
      return r;
   endfunction : exp_word

   task automatic send(input logic w, input logic [`DDS_ADDR_W-1:0] a,
      input logic [4*`DDS_DATA_W-1:0] dt, input logic [4*`DDS_SEL_W-1:0] s);
      int n;
      n = 0;
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_addr  <= a;
      cmd_wdata <= dt;
      cmd_sel_n <= s;
      do
      begin
         @(negedge sys_clk);
         n++;
      end
      while (cmd_ready !== 1'b1 && n < 64);
      @(posedge sys_clk);
      cmd_valid <= 1'b0;
      if (n >= 64)
         n_fail++;
   endtask : send

   // Caller holds rd_ready high
   task automatic pop(input logic [`DDS_DATA_W-1:0] e);
      int n;
      n = 0;
      do
      begin
         @(negedge sys_clk);
         n++;
      end
      while (rd_valid !== 1'b1 && n < 64);
      `CHK(rd_data, e)
      @(posedge sys_clk);
   endtask : pop

   task automatic rd_burst(input logic [`DDS_ADDR_W-1:0] a);
      send(1'b0, a, '0, '1);
      rd_ready <= 1'b1;
      for (int b = 0; b < 4; b++)
         pop(exp4[b]);
      rd_ready <= 1'b0;
   endtask : rd_burst

   ////////////////////////////////////////////////////////////
   initial
   begin
      logic [4*`DDS_DATA_W-1:0] w1;
      logic [4*`DDS_DATA_W-1:0] w2;
      int                       k;
      repeat (6) @(posedge sys_clk);
      rstn <= 1'b1;
      @(negedge sys_clk);
      `CHK(q_wire, {`DDS_DATA_W{1'bz}})
      `CHK(rd_valid, 1'b0)
      foreach (rows[i])
      begin
         @(posedge sys_clk);
         cfg <= rows[i].cfg;
         for (int b = 0; b < 4; b++)
         begin
            w1[36*b +: 36] = rows[i].pat + 36'(b);
            w2[36*b +: 36] = ~w1[36*b +: 36];
            exp4[b] = exp_word(rows[i].cfg, w1[36*b +: 36], w2[36*b +: 36],
               rows[i].sel[4*b +: 4]);
         end
         send(1'b1, rows[i].addr, w1, '0);
         send(1'b1, rows[i].addr, w2, rows[i].sel);
         rd_burst(rows[i].addr);
         $display("Row %0d done", i);
      end
      @(posedge sys_clk);
      single_clock_mode <= 1'b1;
      rd_burst(rows[4].addr);
      $display("Single clock read done");
      // Two bursts fill the FIFO; the third must wait
      send(1'b0, rows[4].addr, '0, '1);
      send(1'b0, rows[4].addr, '0, '1);
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      k = 0;
      repeat (20)
      begin
         @(negedge sys_clk);
         k += (cmd_ready === 1'b1);
      end
      `CHK(k, 0)
      @(posedge sys_clk);
      cmd_valid <= 1'b0;
      rd_ready  <= 1'b1;
      for (int j = 0; j < 8; j++)
         pop(exp4[j % 4]);
      repeat (3) @(negedge sys_clk);
      `CHK(rd_valid, 1'b0)
      `CHK(q_wire, {`DDS_DATA_W{1'bz}})
      @(posedge sys_clk);
      rd_ready <= 1'b0;
      $display("FIFO fill and drain done");
      // Reset lands inside a read burst
      send(1'b0, rows[0].addr, '0, '1);
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      `CHK(u_dds_link_if.q_oe, 1'b0)
      `CHK(rd_valid, 1'b0)
      @(posedge sys_clk);
      rstn <= 1'b1;
      rd_burst(rows[4].addr);
      $display("Mid-burst reset done");
      wrap_up();
   end
endmodule : testbench
